// >>> bitjump_pkg.sv
// Package: constants and carrier types of the bit-test jump decoder
package bitjump_pkg;

  // ****************************************************
  // Opcode match masks and values
  // ****************************************************
  localparam logic [23:0] M_JUMP_IF_BIT_ONE = 24'hFFC0A0;   // Memory jump forms
  localparam logic [23:0] V_J_EA = 24'h0A40A0;   // Indirect ea form
  localparam logic [23:0] V_J_AA = 24'h0A00A0;   // Absolute short
  localparam logic [23:0] V_J_PP = 24'h0A80A0;   // Upper I/O short
  localparam logic [23:0] V_J_QQ = 24'h0180A0;   // Lower I/O short
  localparam logic [23:0] M_JREG = 24'hFFC0E0;   // Register form mask
  localparam logic [23:0] V_JREG = 24'h0AC020;   // Register form
  localparam logic [23:0] M_CEA = 24'hFFC0FF;    // Call by ea mask
  localparam logic [23:0] V_CEA = 24'h0BC080;    // Call by ea
  localparam logic [23:0] M_CSH = 24'hFFF000;    // Short call mask
  localparam logic [23:0] V_CSH = 24'h0D0000;    // Short call

  // ****************************************************
  // Fields, limits and address bases
  // ****************************************************
  localparam logic [4:0] BIT_MAX = 5'h17;        // Highest bit number
  localparam logic [5:0] EA_ABS = 6'h30;         // Absolute ea mode
  localparam logic [23:0] IO_HI = 24'hFFFFC0;    // Upper I/O base
  localparam logic [23:0] IO_LO = 24'hFFFF80;    // Lower I/O base
  localparam int SPACE_BIT = 6;                  // X/Y select bit

  // ****************************************************
  // Register port map
  // ****************************************************
  localparam logic [1:0] REG_CTRL = 2'h0;        // Enable
  localparam logic [1:0] REG_STAT = 2'h1;        // Last result
  localparam logic [1:0] REG_TGT = 2'h2;         // Last new PC
  localparam int CTRL_EN = 0;                    // Enable bit

  // ****************************************************
  // Types
  // ****************************************************
  typedef enum logic [3:0] {
    S_IDLE = 4'h1, S_EXT = 4'h2, S_OPND = 4'h4, S_ADDR = 4'h8
  } fsm_t;
  typedef enum logic [2:0] {
    F_NONE = 3'h0, F_EA = 3'h1, F_AA = 3'h2, F_PP = 3'h3,
    F_QQ = 3'h4, F_REG = 3'h5, F_CEA = 3'h6, F_CSH = 3'h7
  } form_t;
  typedef struct packed {
    logic y_space;        // Y data space when set
    logic is_reg;         // Code names an on-chip register
    logic is_ea;          // Code is an indirect mode for the AGU
    logic [23:0] addr;    // Direct address for short forms
    logic [5:0] code;     // Mode/register or register code
  } opnd_req_t;
  typedef struct packed {
    logic [23:0] data;    // Tested word
    logic [1:0] sl;       // Standard values of flags 7 and 6
  } opnd_rsp_t;
  typedef struct packed {
    logic [23:0] ret;     // Upper stack half
    logic [23:0] status;  // Lower stack half
  } push_t;
  typedef struct packed {
    fsm_t st;
    form_t form;
    logic [23:0] op, pc, ext, pc_val, last_tgt, rdata;
    logic ctrl_en, taken, last_taken;
    logic pc_load, push_v, flags_we, ea_post, illegal;
    logic [7:0] flags;
    push_t push;
    opnd_req_t req;
  } core_t;
  localparam core_t CORE_RST = '{st: S_IDLE, form: F_NONE,
    ctrl_en: 1'b1, default: '0};

endpackage : bitjump_pkg

// >>> bitjump_decode.sv
// Decode and execute of the bit-test jump and subroutine call
//
// Chosen here: the register addresses and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
// How it works
// - Bit set loads extension word target
// - Five-bit field picks bit zero to 23
// - Bit clear advances PC, drops target
// - Address post-update happens either way
// - Indirect modes fetch the jump operand
// - Absolute short and I/O short operands
// - Upper I/O form maps FFFFC0-FFFFFF
// - Lower I/O form maps FFFF80-FFFFBF
// - One opcode bit picks X or Y
// - Register form tests any on-chip register
// - Jump updates flags 7,6 only
// - Call pushes return and status, jumps
// - Call takes alterable ea or extension
// - Short call zero-extends 12-bit target
// - Call leaves all flags unchanged
module bitjump_decode (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Instruction from fetch; pc is the word after the opcode
  input wire logic instr_valid,
  output logic instr_ready,
  input wire logic [23:0] instr_word,
  input wire logic [23:0] instr_pc,
  // Extension word fetch
  output logic ext_req,
  input wire logic ext_valid,
  input wire logic [23:0] ext_word,
  // Operand fetch for the jump
  output logic opnd_req,
  output bitjump_pkg::opnd_req_t opnd,
  input wire logic opnd_valid,
  input wire bitjump_pkg::opnd_rsp_t opnd_rsp,
  // Address generation
  output logic ea_req,
  output logic [5:0] ea_code,
  input wire logic ea_valid,
  input wire logic [23:0] ea_addr,
  output logic ea_post,
  // Program counter, stack and flags
  output logic pc_load,
  output logic [23:0] pc_val,
  output logic push,
  output bitjump_pkg::push_t push_data,
  input wire logic [23:0] status_word,
  output logic flags_we,
  output logic [7:0] flags_out,
  output logic illegal,
  // Register port
  input wire logic [1:0] reg_addr,
  input wire logic [23:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [23:0] reg_rdata
);

  // ****************************************************
  // State
  // ****************************************************
  bitjump_pkg::core_t q;  // Registered state
  bitjump_pkg::core_t d;  // Next state

  // Opcode class match against a mask and value
  function automatic logic hit(input logic [23:0] op,
                               input logic [23:0] m,
                               input logic [23:0] v);
    hit = (op & m) == v;
  endfunction : hit

  // ****************************************************
  // Next-state logic
  // ****************************************************
  always_comb begin
    bitjump_pkg::form_t f;
    logic fin_jump, fin_call;
    logic [23:0] tgt, ret, sh;
    f = bitjump_pkg::F_NONE;
    fin_jump = 1'b0;
    fin_call = 1'b0;
    tgt = '0;
    ret = '0;
    sh = '0;
    d = q;
    // Pulses last one cycle
    d.pc_load = 1'b0;
    d.push_v = 1'b0;
    d.flags_we = 1'b0;
    d.ea_post = 1'b0;
    d.illegal = 1'b0;
    d.rdata = '0;
    // Register writes steer the enable
    if (reg_wr && reg_addr == bitjump_pkg::REG_CTRL) begin
      d.ctrl_en = reg_wdata[bitjump_pkg::CTRL_EN];
    end
    // Read data stand one cycle after the strobe
    if (reg_rd) begin
      case (reg_addr)
        bitjump_pkg::REG_CTRL: d.rdata = {23'h0, q.ctrl_en};
        bitjump_pkg::REG_STAT:
          d.rdata = {19'h0, q.form, q.last_taken,
                     q.st != bitjump_pkg::S_IDLE};
        bitjump_pkg::REG_TGT: d.rdata = q.last_tgt;
        default: d.rdata = '0;
      endcase
    end
    case (q.st)
      // Decode a new opcode
      bitjump_pkg::S_IDLE: begin
        if (instr_valid && q.ctrl_en) begin
          // Fixed prefixes pick the form
          if (hit(instr_word, bitjump_pkg::M_JUMP_IF_BIT_ONE, bitjump_pkg::V_J_EA))
            f = bitjump_pkg::F_EA;
          else if (hit(instr_word, bitjump_pkg::M_JUMP_IF_BIT_ONE,
                       bitjump_pkg::V_J_AA))
            f = bitjump_pkg::F_AA;
          else if (hit(instr_word, bitjump_pkg::M_JUMP_IF_BIT_ONE,
                       bitjump_pkg::V_J_PP))
            f = bitjump_pkg::F_PP;
          else if (hit(instr_word, bitjump_pkg::M_JUMP_IF_BIT_ONE,
                       bitjump_pkg::V_J_QQ))
            f = bitjump_pkg::F_QQ;
          else if (hit(instr_word, bitjump_pkg::M_JREG,
                       bitjump_pkg::V_JREG))
            f = bitjump_pkg::F_REG;
          else if (hit(instr_word, bitjump_pkg::M_CEA, bitjump_pkg::V_CEA))
            f = bitjump_pkg::F_CEA;
          else if (hit(instr_word, bitjump_pkg::M_CSH, bitjump_pkg::V_CSH))
            f = bitjump_pkg::F_CSH;
          d.op = instr_word;
          d.pc = instr_pc;
          d.form = f;
          // Operand description for the fetch side
          d.req.y_space = instr_word[bitjump_pkg::SPACE_BIT];
          d.req.code = instr_word[13:8];
          d.req.is_ea = f == bitjump_pkg::F_EA;
          d.req.is_reg = f == bitjump_pkg::F_REG;
          case (f)
            bitjump_pkg::F_AA:
              d.req.addr = {18'h0, instr_word[13:8]};
            bitjump_pkg::F_PP: begin
              d.req.addr = bitjump_pkg::IO_HI |
                           {18'h0, instr_word[13:8]};
            end
            bitjump_pkg::F_QQ: begin
              d.req.addr = bitjump_pkg::IO_LO |
                           {18'h0, instr_word[13:8]};
            end
            default: d.req.addr = '0;
          endcase
          if (f == bitjump_pkg::F_NONE ||
              (f < bitjump_pkg::F_CEA &&
               instr_word[4:0] > bitjump_pkg::BIT_MAX)) begin
            // Unknown opcode or bit number out of range
            d.illegal = 1'b1;
            d.form = bitjump_pkg::F_NONE;
          end else if (f == bitjump_pkg::F_CSH) begin
            // Short call: no extension word
            fin_call = 1'b1;
            tgt = {12'h0, instr_word[11:0]};
            ret = instr_pc;
          end else if (f == bitjump_pkg::F_CEA &&
                       instr_word[13:8] != bitjump_pkg::EA_ABS) begin
            d.st = bitjump_pkg::S_ADDR;
          end else begin
            d.st = bitjump_pkg::S_EXT;
          end
        end
      end
      // Extension word carries the absolute target
      bitjump_pkg::S_EXT: begin
        if (ext_valid) begin
          d.ext = ext_word;
          if (q.form == bitjump_pkg::F_CEA) begin
            fin_call = 1'b1;
            tgt = ext_word;
            ret = q.pc + 24'h1;
          end else begin
            d.st = bitjump_pkg::S_OPND;
          end
        end
      end
      // Tested word arrives
      bitjump_pkg::S_OPND: begin
        if (opnd_valid) fin_jump = 1'b1;
      end
      // Call target from address generation
      bitjump_pkg::S_ADDR: begin
        if (ea_valid) begin
          fin_call = 1'b1;
          tgt = ea_addr;
          ret = q.pc;
        end
      end
      default: d.st = bitjump_pkg::S_IDLE;
    endcase
    // Finish a jump
    if (fin_jump) begin
      sh = opnd_rsp.data >> q.op[4:0];
      d.taken = sh[0];
      d.pc_val = sh[0] ? q.ext : q.pc + 24'h1;
      d.flags_we = 1'b1;
      d.flags = {opnd_rsp.sl, status_word[5:0]};
      d.ea_post = q.form == bitjump_pkg::F_EA;
    end
    // Finish a call: push and jump in the same cycle, flags untouched
    if (fin_call) begin
      d.taken = 1'b1;
      d.push_v = 1'b1;
      d.push = '{ret: ret, status: status_word};
      d.pc_val = tgt;
    end
    if (fin_jump || fin_call) begin
      d.pc_load = 1'b1;
      d.last_taken = d.taken;
      d.last_tgt = d.pc_val;
      d.st = bitjump_pkg::S_IDLE;
    end
  end

  // ****************************************************
  // State register
  // ****************************************************
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) q <= bitjump_pkg::CORE_RST;
    else q <= d;
  end

  // ****************************************************
  // Outputs
  // ****************************************************
  assign instr_ready = q.st == bitjump_pkg::S_IDLE && q.ctrl_en;
  assign ext_req = q.st == bitjump_pkg::S_EXT;
  assign opnd_req = q.st == bitjump_pkg::S_OPND;
  assign opnd = q.req;
  assign ea_req = q.st == bitjump_pkg::S_ADDR;
  assign ea_code = q.op[13:8];
  assign ea_post = q.ea_post;
  assign pc_load = q.pc_load;
  assign pc_val = q.pc_val;
  assign push = q.push_v;
  assign push_data = q.push;
  assign flags_we = q.flags_we;
  assign flags_out = q.flags;
  assign illegal = q.illegal;
  assign reg_rdata = q.rdata;

  // ****************************************************
  // Assertions
  // ****************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  logic is_jump;  // Last finished op was a jump
  assign is_jump = q.form != bitjump_pkg::F_CEA &&
                   q.form != bitjump_pkg::F_CSH;

  // Jump outcome: target when set, next word when clear
  AST_TAKEN: assert property (
    pc_load && is_jump && q.taken |-> pc_val == q.ext)
    else $error("taken jump lost target");
  AST_NOT_TAKEN: assert property (
    pc_load && is_jump && !q.taken |-> pc_val == q.pc + 24'h1)
    else $error("bad fall-through address");
  // A bit number above 23 is refused in the absolute short form
  AST_BIT_RANGE: assert property (
    instr_valid && instr_ready &&
    instr_word[4:0] > bitjump_pkg::BIT_MAX &&
    hit(instr_word, bitjump_pkg::M_JUMP_IF_BIT_ONE, bitjump_pkg::V_J_AA)
    |=> illegal) else $error("bit number above 23 accepted");
  // Post-update on both outcomes of the indirect form, and only there
  AST_EA_POST: assert property (
    ea_post == (pc_load && q.form == bitjump_pkg::F_EA))
    else $error("post-update wrong");
  // Short operand addresses land in their windows
  AST_AA_MAP: assert property (
    opnd_req && q.form == bitjump_pkg::F_AA |-> opnd.addr[23:6] == 18'h0)
    else $error("absolute short map");
  AST_IO_HI: assert property (
    opnd_req && q.form == bitjump_pkg::F_PP |-> opnd.addr[23:6] == 18'h3FFFF)
    else $error("upper I/O map");
  AST_IO_LO: assert property (
    opnd_req && q.form == bitjump_pkg::F_QQ |-> opnd.addr[23:6] == 18'h3FFFE)
    else $error("lower I/O map");
  // Operand kind flags follow the decoded form
  AST_REG_FORM: assert property (
    opnd_req |-> opnd.is_reg == (q.form == bitjump_pkg::F_REG) &&
    opnd.is_ea == (q.form == bitjump_pkg::F_EA)) else $error("operand kind");
  // Jump keeps the six low flags
  AST_FLAGS: assert property (
    flags_we |-> flags_out[5:0] == $past(status_word[5:0]))
    else $error("low flags");
  // Call pushes the status word and writes no flags
  AST_CALL: assert property (
    push |-> pc_load && !flags_we &&
    push_data.status == $past(status_word)) else $error("call push");
  AST_RET: assert property (
    push && q.form == bitjump_pkg::F_CSH |-> push_data.ret == q.pc)
    else $error("short call return");
  AST_SHORT: assert property (
    instr_valid && instr_ready &&
    hit(instr_word, bitjump_pkg::M_CSH, bitjump_pkg::V_CSH) |=>
    push && pc_val == {12'h0, $past(instr_word[11:0])})
    else $error("short call target");
  // Extension only for forms that carry one
  AST_EXT_ONLY: assert property (
    ext_req |-> q.form != bitjump_pkg::F_CSH)
    else $error("extension on short form");
  // A refused opcode changes nothing else
  AST_QUIET: assert property (
    illegal |-> !pc_load && !push && !flags_we && !ea_post)
    else $error("refused opcode acted");
  // Main scenarios
  COV_TAKEN: cover property (pc_load && is_jump && q.taken);
  COV_NOT_TAKEN: cover property (pc_load && is_jump && !q.taken);
  COV_CALL: cover property (ext_req ##[1:8] push);
  COV_SHORT: cover property (push && q.form == bitjump_pkg::F_CSH);
  COV_REFUSED: cover property (illegal);

endmodule : bitjump_decode
`default_nettype wire

// >>> far_side_model.sv
// Far-side model: extension, operand and call address answers
`timescale 1ns/10ps
`default_nettype none
module far_side_model (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Answer values and lag set by the bench
  input wire logic [1:0] lag,
  input wire logic [23:0] ext_v,
  input wire logic [25:0] rsp_v,
  input wire logic [23:0] ea_v,
  // Requests from the decoder
  input wire logic ext_req,
  input wire logic opnd_req,
  input wire logic ea_req,
  // Answers to the decoder
  output logic ext_valid,
  output logic opnd_valid,
  output logic ea_valid,
  output logic [23:0] ext_word,
  output bitjump_pkg::opnd_rsp_t opnd_rsp,
  output logic [23:0] ea_addr
);
  logic [1:0] wait_q; // Cycles spent on the open request
  logic hit_q; // Answer cycle
  logic busy; // A request waits for its answer
  assign busy = (ext_req || opnd_req || ea_req) && !hit_q;
  // Count lag cycles, then answer for exactly one cycle
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wait_q <= 2'h0;
      hit_q <= 1'b0;
    end else begin
      hit_q <= busy && wait_q == lag;
      wait_q <= (busy && wait_q != lag) ? wait_q + 2'h1 : 2'h0;
    end
  end
  // Each answer goes only to the request that is open
  assign ext_valid = hit_q & ext_req;
  assign opnd_valid = hit_q & opnd_req;
  assign ea_valid = hit_q & ea_req;
  // Released lines show the inverse, never a stale match
  assign ext_word = ext_valid ? ext_v : ~ext_v;
  assign opnd_rsp = bitjump_pkg::opnd_rsp_t'(opnd_valid ? rsp_v : ~rsp_v);
  assign ea_addr = ea_valid ? ea_v : ~ea_v;
endmodule : far_side_model
`default_nettype wire

// >>> tb_bit_test_jump_and_call_decode.sv
// Testbench of the bit-test jump and subroutine call decoder
`timescale 1ns/10ps
`default_nettype none
module tb_bit_test_jump_and_call_decode;
  // Design and model connections
  logic clock, rstn, instr_valid, instr_ready, ext_req, ext_valid, push;
  logic opnd_req, opnd_valid, ea_req, ea_valid, ea_post, pc_load, s_ext;
  logic flags_we, illegal, reg_wr, reg_rd, s_ea;
  logic [1:0] reg_addr, lag;
  logic [5:0] ea_code;
  logic [7:0] flags_out;
  logic [25:0] rsp_v;
  logic [23:0] instr_word, instr_pc, ext_word, ea_addr, pc_val, reg_wdata;
  logic [23:0] status_word, reg_rdata, ext_v, ea_v, rd;
  bitjump_pkg::opnd_req_t opnd, s_opnd;
  bitjump_pkg::opnd_rsp_t opnd_rsp;
  bitjump_pkg::push_t push_data;
  int err_total, n_checks;
  bitjump_decode uut (.clock(clock), .rstn(rstn), .instr_valid(instr_valid),
    .instr_ready(instr_ready), .instr_word(instr_word), .instr_pc(instr_pc),
    .ext_req(ext_req), .ext_valid(ext_valid), .ext_word(ext_word),
    .opnd_req(opnd_req), .opnd(opnd), .opnd_valid(opnd_valid),
    .opnd_rsp(opnd_rsp), .ea_req(ea_req), .ea_code(ea_code),
    .ea_valid(ea_valid), .ea_addr(ea_addr), .ea_post(ea_post),
    .pc_load(pc_load), .pc_val(pc_val), .push(push), .push_data(push_data),
    .status_word(status_word), .flags_we(flags_we), .flags_out(flags_out),
    .illegal(illegal), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  far_side_model far (.clock(clock), .rstn(rstn), .lag(lag), .ext_v(ext_v),
    .rsp_v(rsp_v), .ea_v(ea_v), .ext_req(ext_req), .opnd_req(opnd_req),
    .ea_req(ea_req), .ext_valid(ext_valid), .opnd_valid(opnd_valid),
    .ea_valid(ea_valid), .ext_word(ext_word), .opnd_rsp(opnd_rsp),
    .ea_addr(ea_addr));
  // Clock of 100 ns period
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  // Counts, verdict and end of run
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : stop_test
  // A bounded wait ran out
  task automatic give_up(input string what);
    err_total++;
    $display("unexpected at %0t: no %s", $time, what);
    stop_test();
  endtask : give_up
  // Word and flag compares
  task automatic cmp_w(input logic [23:0] got, want, input string what);
    n_checks++;
    if (got !== want) begin
      err_total++;
      $display("unexpected at %0t: %s %h not %h", $time, what, got, want);
    end
  endtask : cmp_w
  task automatic cmp_b(input logic got, want, input string what);
    cmp_w({23'h0, got}, {23'h0, want}, what);
  endtask : cmp_b
  // Register port: one-cycle strobes, read data in the next cycle
  task automatic reg_write(input logic [1:0] a, input logic [23:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : reg_write
  task automatic reg_read(input logic [1:0] a, output logic [23:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(negedge clock);
    d = reg_rdata;
  endtask : reg_read
  // Offer one opcode, then watch until its load or refusal
  task automatic run_op(input logic [23:0] op, at, st);
    int k;
    s_ext = 1'b0;
    s_ea = 1'b0;
    s_opnd = '0;
    @(posedge clock);
    instr_word <= op;
    instr_pc <= at;
    status_word <= st;
    instr_valid <= 1'b1;
    k = 0;
    do begin
      @(negedge clock);
      k++;
    end while (instr_ready !== 1'b1 && k < 20);
    if (k == 20) give_up("take");
    @(posedge clock);
    instr_valid <= 1'b0;
    for (k = 0; k < 30; k++) begin
      @(negedge clock);
      if (ext_req === 1'b1) s_ext = 1'b1;
      if (ea_req === 1'b1) s_ea = 1'b1;
      if (opnd_req === 1'b1) s_opnd = opnd;
      if (pc_load === 1'b1 || illegal === 1'b1) break;
    end
    if (k == 30) give_up("finish");
  endtask : run_op
  // Every jump form, taken and not, bit 23 and bit 0, fast and slow
  task automatic t_jump();
    logic [23:0] base [5];
    logic [5:0] code [5];
    logic [23:0] want [5];
    logic [23:0] at;
    logic [4:0] n;
    logic y, hit;
    base = '{bitjump_pkg::V_J_EA, bitjump_pkg::V_J_AA, bitjump_pkg::V_J_PP,
      bitjump_pkg::V_J_QQ, bitjump_pkg::V_JREG};
    code = '{6'h1A, 6'h3F, 6'h3F, 6'h00, 6'h04};
    want = '{24'h0, 24'h00003F, 24'hFFFFFF, 24'hFFFF80, 24'h0};
    for (int i = 0; i < 10; i++) begin
      hit = i[0];
      n = i[1] ? 5'h17 : 5'h00;
      y = i[2] && i < 8;
      lag = 2'(i % 3);
      ext_v = 24'h100000 + 24'(i);
      rsp_v = {hit ? 24'h1 << n : ~(24'h1 << n), 2'(i)};
      at = 24'h000200 + 24'(i * 16);
      run_op(base[i / 2] | {10'h0, code[i / 2], 1'b0, y, 1'b0, n}, at,
        24'hFFFF2A);
      cmp_w(pc_val, hit ? ext_v : at + 24'h1, "jump pc");
      cmp_w({16'h0, flags_out}, {16'h0, rsp_v[1:0], 6'h2A}, "flags");
      cmp_b(flags_we, 1'b1, "flag write");
      cmp_b(ea_post, i < 2, "post update");
      cmp_b(s_opnd.y_space, y, "space");
      cmp_b(s_opnd.is_reg, i > 7, "reg form");
      cmp_b(s_opnd.is_ea, i < 2, "ea form");
      cmp_b(s_ext, 1'b1, "extension");
      if (i / 2 % 4 == 0) cmp_w({18'h0, s_opnd.code}, {18'h0, code[i / 2]}, "code");
      else cmp_w(s_opnd.addr, want[i / 2], "short addr");
    end
  endtask : t_jump
  // Short calls to FFF and 001, call by extension, call by address unit
  task automatic t_call();
    logic [23:0] ops [4];
    logic [23:0] tgt [4];
    ops = '{bitjump_pkg::V_CSH | 24'hFFF, bitjump_pkg::V_CSH | 24'h001,
      bitjump_pkg::V_CEA | 24'h3000, bitjump_pkg::V_CEA | 24'h1A00};
    tgt = '{24'h000FFF, 24'h000001, 24'h123456, 24'h00ABCD};
    ext_v = 24'h123456;
    ea_v = 24'h00ABCD;
    lag = 2'h2;
    for (int i = 0; i < 4; i++) begin
      run_op(ops[i], 24'h000300, 24'hA5A5A5);
      cmp_w(pc_val, tgt[i], "call target");
      cmp_b(push, 1'b1, "push");
      cmp_w(push_data.ret, 24'h000300 + 24'(i == 2), "return");
      cmp_w(push_data.status, 24'hA5A5A5, "status");
      cmp_b(flags_we, 1'b0, "flags kept");
      cmp_b(s_ext, i == 2, "extension");
      cmp_b(s_ea, i == 3, "address unit");
    end
    cmp_w({18'h0, ea_code}, 24'h00001A, "ea code");
    reg_read(bitjump_pkg::REG_TGT, rd);
    cmp_w(rd, 24'h00ABCD, "last target");
    // Form 6 (call by ea), last taken, not busy
    reg_read(bitjump_pkg::REG_STAT, rd);
    cmp_w(rd, 24'h00001A, "last form and outcome");
  endtask : t_call
  // Bit number 24 and an unknown opcode are refused
  task automatic t_bad();
    run_op(bitjump_pkg::V_J_AA | 24'h18, 24'h000400, 24'h0);
    cmp_b(illegal, 1'b1, "bit 24");
    cmp_b(pc_load, 1'b0, "no load");
    run_op(24'h000000, 24'h000400, 24'h0);
    cmp_b(illegal, 1'b1, "unknown");
  endtask : t_bad
  // Reset in mid-run clears results and sets the enable again
  task automatic t_reset();
    reg_write(bitjump_pkg::REG_CTRL, 24'h0);
    @(posedge clock);
    rstn <= 1'b0;
    @(negedge clock);
    cmp_w(pc_val, 24'h0, "target after reset");
    cmp_b(pc_load, 1'b0, "no load in reset");
    cmp_b(instr_ready, 1'b1, "enable after reset");
    @(posedge clock);
    rstn <= 1'b1;
    run_op(bitjump_pkg::V_CSH | 24'h0AB, 24'h000500, 24'h0);
    cmp_w(pc_val, 24'h0000AB, "first op after reset");
    cmp_w(push_data.ret, 24'h000500, "return after reset");
  endtask : t_reset
  // Reset values, unmapped place, read data width, enable
  task automatic t_regs();
    reg_read(bitjump_pkg::REG_CTRL, rd);
    cmp_w(rd, 24'h000001, "enable reset");
    @(negedge clock);
    cmp_w(reg_rdata, 24'h0, "read data gone");
    reg_write(2'h3, 24'hFFFFFF);
    reg_read(2'h3, rd);
    cmp_w(rd, 24'h0, "unmapped");
    reg_write(bitjump_pkg::REG_CTRL, 24'h0);
    @(negedge clock);
    cmp_b(instr_ready, 1'b0, "disabled");
    reg_write(bitjump_pkg::REG_CTRL, 24'h000001);
  endtask : t_regs
  // Main sequence
  initial begin
    {rstn, instr_valid, reg_wr, reg_rd, reg_addr, lag} = '0;
    {instr_word, instr_pc, status_word, reg_wdata} = '0;
    {ext_v, ea_v, rsp_v} = '0;
    err_total = 0;
    n_checks = 0;
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    t_regs();
    $display("done: registers");
    t_jump();
    $display("done: jump forms");
    t_call();
    $display("done: calls");
    t_bad();
    $display("done: refusals");
    t_reset();
    $display("done: reset");
    stop_test();
  end
endmodule : tb_bit_test_jump_and_call_decode
`default_nettype wire
